// ---- logic/aps_pkg.sv ----
// shared constants and types for the arbitrary pulse shaper
package aps_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [4:0] LINE_CTRL_CH1_ADDR = 5'h16;
  localparam logic [4:0] LINE_CTRL_CH2_ADDR = 5'h17;
  localparam logic [4:0] SHAPE_ENTRY_CH1_ADDR = 5'h18;
  localparam logic [4:0] SHAPE_ENTRY_CH2_ADDR = 5'h19;
  localparam logic [7:0] SHAPE_INDEX_MAX = 8'h29;

  // control register fields
  localparam int FORCE_ONES_BIT = 7;
  localparam int FAR_LOOP_BIT = 6;
  localparam int NEAR_A_BIT = 5;
  localparam int NEAR_B_BIT = 4;
  localparam int CFG_MSB = 3;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h0e;

  // arbitrary configuration codes
  localparam logic [3:0] CFG_E1_COAX = 4'h8;
  localparam logic [3:0] CFG_E1_TP = 4'h9;
  localparam logic [3:0] CFG_DSX1 = 4'ha;
  localparam logic [3:0] CFG_DS1 = 4'hb;

  // ---------------------------------------------------------------
  // shape geometry and amplitude range
  // ---------------------------------------------------------------
  localparam int CHANNELS = 2;
  localparam int UI_SPAN = 3;
  localparam int PHASES_MAX = 14;
  localparam int ENTRIES = UI_SPAN * PHASES_MAX;
  localparam logic [3:0] PHASES_DS1 = 4'd14;
  localparam logic [3:0] PHASES_DSX1 = 4'd13;
  localparam logic [3:0] PHASES_E1 = 4'd12;
  localparam logic signed [8:0] AMP_POS_FULL = 9'sh03f;
  localparam logic signed [8:0] AMP_NEG_FULL = -9'sh040;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int UI_T1_NS = 648;
  localparam int UI_E1_NS = 488;
  localparam int PHASE_DS1_PS = 46300;
  localparam int PHASE_DSX1_PS = 49800;
  localparam int PHASE_E1_PS = 40700;
  localparam int PHASE_DS1_CYC = (PHASE_DS1_PS / CLK_PERIOD_PS) < 1 ? 1 : PHASE_DS1_PS / CLK_PERIOD_PS;
  localparam int PHASE_DSX1_CYC = (PHASE_DSX1_PS / CLK_PERIOD_PS) < 1 ? 1 : PHASE_DSX1_PS / CLK_PERIOD_PS;
  localparam int PHASE_E1_CYC = (PHASE_E1_PS / CLK_PERIOD_PS) < 1 ? 1 : PHASE_E1_PS / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] index;
    logic [7:0] wdata;
  } aps_host_req_s;

  typedef struct packed {
    logic mark;
    logic [6:0] amp;
  } aps_sample_s;

endpackage

// ---- logic/aps_shaper.sv ----
// dual-channel arbitrary transmit pulse shaper with its control registers
`timescale 1ns/1ps
module aps_shaper (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // host register port
  input aps_pkg::aps_host_req_s host_req,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  // transmit symbols and receive data, one bit per channel
  input wire logic [aps_pkg::CHANNELS-1:0] tx_mark,
  output logic [aps_pkg::CHANNELS-1:0] tx_take,
  input wire logic [aps_pkg::CHANNELS-1:0] rx_data_in,
  output logic [aps_pkg::CHANNELS-1:0] rx_data_out,
  // driver sample stream
  output aps_pkg::aps_sample_s [aps_pkg::CHANNELS-1:0] dac_sample,
  output logic [aps_pkg::CHANNELS-1:0] dac_valid,
  input wire logic [aps_pkg::CHANNELS-1:0] dac_ready,
  // status
  input wire logic [aps_pkg::CHANNELS-1:0] ovf_clear,
  output logic [aps_pkg::CHANNELS-1:0] ovf_flag,
  output logic [aps_pkg::CHANNELS-1:0] arb_active
);
  import aps_pkg::*;

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic logic is_arb(input logic [3:0] cfg);
    is_arb = (cfg == CFG_E1_COAX) || (cfg == CFG_E1_TP) || (cfg == CFG_DSX1) || (cfg == CFG_DS1);
  endfunction

  function automatic logic [3:0] phases_of(input logic [3:0] cfg);
    if (cfg == CFG_DS1) begin
      phases_of = PHASES_DS1;
    end else if (cfg == CFG_DSX1) begin
      phases_of = PHASES_DSX1;
    end else if (is_arb(cfg)) begin
      phases_of = PHASES_E1;
    end else begin
      phases_of = PHASES_DS1;
    end
  endfunction

  function automatic logic [7:0] phase_cycles(input logic [3:0] cfg);
    if (cfg == CFG_DSX1) begin
      phase_cycles = 8'(PHASE_DSX1_CYC);
    end else if (cfg == CFG_E1_COAX || cfg == CFG_E1_TP) begin
      phase_cycles = 8'(PHASE_E1_CYC);
    end else begin
      phase_cycles = 8'(PHASE_DS1_CYC);
    end
  endfunction

  // sign-extend an entry, ignoring its top bit
  function automatic logic signed [8:0] amp_of(input logic [7:0] entry);
    amp_of = {{2{entry[6]}}, entry[6:0]};
  endfunction

  logic [7:0] ctrl_q [CHANNELS];
  logic [7:0] entry_rd [CHANNELS];

  // ---------------------------------------------------------------
  // host read path, answered one cycle after the request
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_req.rd;
      if (host_req.rd) begin
        unique case (host_req.addr)
          LINE_CTRL_CH1_ADDR: host_rdata <= ctrl_q[0];
          LINE_CTRL_CH2_ADDR: host_rdata <= ctrl_q[1];
          SHAPE_ENTRY_CH1_ADDR: host_rdata <= entry_rd[0];
          SHAPE_ENTRY_CH2_ADDR: host_rdata <= entry_rd[1];
          default: host_rdata <= 8'h00; // unmapped reads as zero
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // per-channel shaper
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    logic [7:0] shape [ENTRIES];
    logic [3:0] phase;
    logic [7:0] cyc;
    logic [UI_SPAN-1:0] hist;
    logic [1:0] buf_cnt;
    aps_sample_s buf0;
    aps_sample_s buf1;
    logic [3:0] cfg;
    logic arb;
    logic step;
    logic push;
    logic pop;
    logic next_mark;
    logic signed [8:0] sum;
    logic ovf;
    aps_sample_s next_sample;
    logic [4:0] ctrl_addr;
    logic [4:0] entry_addr;

    assign ctrl_addr = ch == 0 ? LINE_CTRL_CH1_ADDR : LINE_CTRL_CH2_ADDR;
    assign entry_addr = ch == 0 ? SHAPE_ENTRY_CH1_ADDR : SHAPE_ENTRY_CH2_ADDR;
    assign cfg = ctrl_q[ch][CFG_MSB:0];
    assign arb = is_arb(cfg);

    // control register, written value takes effect next cycle
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        ctrl_q[ch] <= LINE_CTRL_RESET;
      end else if (host_req.wr && host_req.addr == ctrl_addr) begin
        ctrl_q[ch] <= host_req.wdata;
      end
    end

    // shape memory; out-of-range index writes are dropped
    always_ff @(posedge mclk) begin
      if (host_req.wr && host_req.addr == entry_addr && host_req.index <= SHAPE_INDEX_MAX) begin
        shape[host_req.index[5:0]] <= host_req.wdata;
      end
    end
    assign entry_rd[ch] = host_req.index <= SHAPE_INDEX_MAX ? shape[host_req.index[5:0]] : 8'h00;

    // three overlapping contributions summed in 9-bit signed, then clamped
    always_comb begin
      sum = 9'sd0;
      for (int k = 0; k < UI_SPAN; k++) begin
        if (hist[k]) begin
          sum = sum + amp_of(shape[k * PHASES_MAX + int'(phase)]);
        end
      end
      ovf = 1'b0;
      next_sample.mark = hist[0];
      if (!arb) begin
        next_sample.amp = 7'h00; // predefined shapes are produced elsewhere
      end else if (sum > AMP_POS_FULL) begin
        next_sample.amp = AMP_POS_FULL[6:0];
        ovf = 1'b1;
      end else if (sum < AMP_NEG_FULL) begin
        next_sample.amp = AMP_NEG_FULL[6:0];
        ovf = 1'b1;
      end else begin
        next_sample.amp = sum[6:0];
      end
    end

    // a phase ends when its cycle count runs out and the buffer has room
    assign step = (cyc == 8'h00) && (buf_cnt != 2'd2);
    assign push = step;
    assign pop = (buf_cnt != 2'd0) && dac_ready[ch];
    assign next_mark = ctrl_q[ch][FORCE_ONES_BIT] | (ctrl_q[ch][FAR_LOOP_BIT] ? rx_data_in[ch] : tx_mark[ch]);

    // phase sequencer; unused trailing entries of each interval are skipped
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        cyc <= 8'h00;
        phase <= 4'd0;
      end else if (step) begin
        cyc <= phase_cycles(cfg) - 8'h01;
        if (phase >= phases_of(cfg) - 4'd1) begin
          phase <= 4'd0;
        end else begin
          phase <= phase + 4'd1;
        end
      end else if (cyc != 8'h00) begin
        cyc <= cyc - 8'h01;
      end
    end

    // symbol history: bit 0 is the current interval, bits 1 and 2 the tails
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        hist <= '0;
        tx_take[ch] <= 1'b0;
      end else begin
        tx_take[ch] <= 1'b0;
        if (step && phase >= phases_of(cfg) - 4'd1) begin
          hist <= {hist[UI_SPAN-2:0], next_mark};
          tx_take[ch] <= 1'b1;
        end
      end
    end

    // two-entry buffer toward the driver; a stall holds the sequencer, never drops
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        buf_cnt <= 2'd0;
        buf0 <= '0;
        buf1 <= '0;
        dac_valid[ch] <= 1'b0;
      end else begin
        // valid is registered from the next count so the port comes straight from a flop
        dac_valid[ch] <= (buf_cnt != 2'd0 || push) && !(buf_cnt == 2'd1 && pop && !push);
        unique case ({push, pop})
          2'b10: begin
            if (buf_cnt == 2'd0) begin
              buf0 <= next_sample;
            end else begin
              buf1 <= next_sample;
            end
            buf_cnt <= buf_cnt + 2'd1;
          end
          2'b01: begin
            buf0 <= buf1;
            buf_cnt <= buf_cnt - 2'd1;
          end
          2'b11: begin
            if (buf_cnt == 2'd1) begin
              buf0 <= next_sample;
            end else begin
              buf0 <= buf1;
              buf1 <= next_sample;
            end
          end
          2'b00: begin
            buf_cnt <= buf_cnt;
          end
        endcase
      end
    end
    assign dac_sample[ch] = buf0;

    // sticky overflow; a new overflow wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        ovf_flag[ch] <= 1'b0;
      end else if (push && ovf) begin
        ovf_flag[ch] <= 1'b1;
      end else if (ovf_clear[ch]) begin
        ovf_flag[ch] <= 1'b0;
      end
    end

    // receive data and mode flag
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        rx_data_out[ch] <= 1'b0;
        arb_active[ch] <= 1'b0;
      end else begin
        rx_data_out[ch] <= (ctrl_q[ch][NEAR_A_BIT] & ctrl_q[ch][NEAR_B_BIT]) | rx_data_in[ch];
        arb_active[ch] <= arb;
      end
    end
  end

endmodule

// ---- verif/aps_dac_sink.sv ----
// transmit driver model that takes samples with random stalls
`timescale 1ns/1ps
module aps_dac_sink (
  // clock, reset and stall mode
  input wire logic mclk,
  input wire logic resetn,
  input wire logic stall_en,
  // stream handshake
  output logic [1:0] dac_ready
);
  int seed = 32'h6735;
  // rare ready while stalling, so the two-entry buffer fills and the sequencer must wait
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn) dac_ready <= 2'b00;
    else dac_ready <= stall_en ? {2{($random(seed) & 15) == 0}} : 2'b11;
endmodule

// ---- verif/aps_shaper_monitor.sv ----
// port checker for the arbitrary pulse shaper
`timescale 1ns/1ps
module aps_shaper_monitor
  import aps_pkg::*;
(
  // every shaper port, seen as an input
  input wire logic mclk,
  input wire logic resetn,
  input aps_pkg::aps_host_req_s host_req,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic [1:0] tx_mark,
  input wire logic [1:0] tx_take,
  input wire logic [1:0] rx_data_in,
  input wire logic [1:0] rx_data_out,
  input aps_pkg::aps_sample_s [1:0] dac_sample,
  input wire logic [1:0] dac_valid,
  input wire logic [1:0] dac_ready,
  input wire logic [1:0] ovf_clear,
  input wire logic [1:0] ovf_flag,
  input wire logic [1:0] arb_active
);
  logic [7:0] sh [2];
  logic arb0;
  logic near0;
  // decoded fields of the channel one shadow
  assign arb0 = sh[0][3:2] == 2'b10;
  assign near0 = sh[0][5] & sh[0][4];
  // shadow of both control registers, written on the same edge as the shaper's own
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn) sh <= '{LINE_CTRL_RESET, LINE_CTRL_RESET};
    else if (host_req.wr && host_req.addr[4:1] == 4'hb) sh[host_req.addr[0]] <= host_req.wdata;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_read_ctrl;
    host_req.rd && host_req.addr[4:1] == 4'hb;
  endsequence
  // shortest interval is 12 phases of 8 cycles, so eight quiet cycles is a safe floor
  sequence s_gap;
    !tx_take[0] [*8];
  endsequence
  property p_readback;
    logic [7:0] v;
    (s_read_ctrl, v = sh[host_req.addr[0]]) |=> host_rdata == v;
  endproperty
  a_read_answer: assert property (host_req.rd |=> host_rvalid) else $error("no read answer");
  a_answer_cause: assert property (host_rvalid |-> $past(host_req.rd)) else $error("stray answer");
  a_ctrl_readback: assert property (p_readback) else $error("bad readback");
  a_arb_follows: assert property ($past(resetn) |-> arb_active[0] == $past(arb0)) else $error("bad arb");
  a_rx_ones: assert property ($past(resetn) |-> rx_data_out[0] == ($past(near0) | $past(rx_data_in[0])))
    else $error("bad rx");
  a_sample_hold: assert property (dac_valid[0] && !dac_ready[0] |=> dac_valid[0] && $stable(dac_sample[0]))
    else $error("sample lost");
  a_take_valid: assert property (tx_take[0] |-> dac_valid[0]) else $error("take without sample");
  a_take_gap: assert property (tx_take[0] |=> s_gap) else $error("interval too short");
  a_ovf_sticky: assert property (ovf_flag[0] && !ovf_clear[0] |=> ovf_flag[0]) else $error("flag fell");
endmodule

// ---- verif/aps_shaper_tb_top.sv ----
// self-checking bench for the arbitrary pulse shaper
`timescale 1ns/1ps
module aps_shaper_tb_top;
  import aps_pkg::*;
  logic mclk = 0, resetn = 0, stall_en = 0, run = 0, arm = 0, ovf_exp = 0, host_rvalid, sync_now;
  logic [1:0] tx_mark = 0, rx_data_in = 0, ovf_clear = 0, tx_take, rx_data_out, dac_valid, dac_ready;
  logic [1:0] ovf_flag, arb_active;
  logic [7:0] host_rdata, q, ctrl;
  logic [7:0] shape [42];
  logic [2:0] hist;
  logic exp_q [$];
  aps_host_req_s host_req = '0;
  aps_sample_s [1:0] dac_sample;
  int seed = 32'h6735, fails = 0, compares = 0, ph, nph, pops, n, s;
  int code [5] = '{11, 10, 8, 9, 14}, phs [5] = '{14, 13, 12, 12, 14}, cyc [5] = '{9, 9, 8, 8, 9};
  aps_shaper aps_shaper_inst (.*);
  aps_dac_sink aps_dac_sink_inst (.mclk(mclk), .resetn(resetn), .stall_en(stall_en), .dac_ready(dac_ready));
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // one strobe cycle; read data is caught 1 ns after the edge that takes the request
  task automatic hreq(input logic w, input logic r, input logic [4:0] a, input logic [7:0] i, input logic [7:0] d);
    host_req <= '{w, r, a, i, d};
    @(posedge mclk);
    host_req <= '0;
    #1 q = host_rvalid ? host_rdata : 8'hxx;
    @(posedge mclk);
  endtask
  function automatic int exp_sum(input int p);
    int t = 0;
    for (int k = 0; k < 3; k++) if (hist[k]) t += $signed(shape[14 * k + p][6:0]);
    return ctrl[3:2] == 2'b10 ? t : 0;
  endfunction
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #2.5 mclk = ~mclk;
  // sample stream scoreboard; the pop seen with a take is the last phase of the old interval
  always @(posedge mclk) begin
    sync_now = arm && !run && tx_take[0] && dac_ready[0];
    // the overflow flag is cleared as the count starts, so only scored samples can set it
    ovf_clear <= {1'b0, sync_now};
    if (sync_now) begin
      run = 1;
      ph = nph - 1;
      pops = 0;
      hist = {3{ctrl[7]}};
      exp_q = {};
      ovf_exp = 0;
    end
    if (run && tx_take[0]) begin
      exp_q.push_back(ctrl[7] | (ctrl[6] ? rx_data_in[0] : tx_mark[0]));
      tx_mark <= 2'($random(seed));
      rx_data_in <= 2'($random(seed));
    end
    if (run && dac_valid[0] && dac_ready[0]) begin
      if (ph == 0) begin
        hist = {hist[1:0], dac_sample[0].mark};
        chk(dac_sample[0].mark, exp_q.pop_front());
      end
      s = exp_sum(ph);
      if (!sync_now && (s > 63 || s < -64)) ovf_exp = 1;
      chk(dac_sample[0].amp, s > 63 ? 7'h3f : s < -64 ? 7'h40 : 7'(s));
      ph = (ph + 1) % nph;
      pops++;
    end
  end
  // reset values, shape loading, control codes, then one stream run per arbitrary configuration and one for code 14
  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1;
    @(posedge mclk);
    chk(arb_active, 0);
    for (int a = 0; a < 3; a++) begin
      hreq(0, 1, a == 2 ? 5'h10 : 5'h16 + 5'(a), 0, 0);
      chk(q, a == 2 ? 8'h00 : 8'h0e);
    end
    for (int i = 0; i < 42; i++) begin
      shape[i] = 8'($random(seed));
      hreq(1, 0, 5'h18, 8'(i), shape[i]);
      hreq(1, 0, 5'h19, 8'(i), ~shape[i]);
    end
    hreq(1, 0, 5'h18, 8'h2a, 8'h11);
    for (int i = 0; i < 3; i++) begin
      n = i == 2 ? 42 : i * 41;
      hreq(0, 1, 5'h18, 8'(n), 0);
      chk(q & 8'h7f, n == 42 ? 8'h00 : shape[n % 42] & 8'h7f);
    end
    for (int c = 0; c < 16; c++) begin
      ctrl = {4'($random(seed)), 4'(c)};
      n = $random(seed) & 1;
      hreq(1, 0, 5'h16 + 5'(n), 0, ctrl);
      hreq(0, 1, 5'h16 + 5'(n), 0, 0);
      chk(q, ctrl);
      chk(arb_active[n], c > 7 && c < 12);
    end
    $display("register test done");
    foreach (code[i]) begin
      nph = phs[i];
      ctrl = {4'($random(seed)), 4'(code[i])};
      stall_en <= 0;
      tx_mark <= 0;
      rx_data_in <= 0;
      hreq(1, 0, 5'h16, 0, ctrl);
      repeat (601) @(posedge mclk);
      arm = 1;
      for (n = 0; n < 900 && !run; n++) @(negedge mclk);
      if (!run) begin
        fails++;
        report_and_stop();
      end
      for (n = 1; n < 300 && !tx_take[0]; n++) @(negedge mclk);
      chk(8'(n), 8'(nph * cyc[i]));
      stall_en <= 1;
      for (n = 0; n < 40000 && pops < 150; n++) @(negedge mclk);
      chk(8'(pops >= 150), 1);
      stall_en <= 0;
      for (n = 0; n < 50 && dac_valid[0]; n++) @(negedge mclk);
      chk(8'(dac_valid[0]), 0);
      run = 0;
      arm = 0;
      chk(ovf_flag[0], ovf_exp);
      $display("stream test %0d done", i);
    end
    report_and_stop();
  end
endmodule
bind aps_shaper aps_shaper_monitor aps_shaper_monitor_inst (.*);
